// file: verilog/pscc_regs.svh
// Register map, field positions, reset values and timing counts of the
// pulse sequencer channel control block. Definitions only.
`ifndef PSCC_REGS_SVH
`define PSCC_REGS_SVH
`define PSCC_A_STATUS 32'h0600000C
`define PSCC_A_DLY_LO 32'h60000010
`define PSCC_A_DLY_HI 32'h60000014
`define PSCC_A_LSTART 32'h60000018
`define PSCC_A_SEQRST 32'h6000001C
`define PSCC_A_IRQ_MASK 32'h06000020
`define PSCC_A_IRQ_PEND 32'h60000024
`define PSCC_A_CHCFG 32'h60000030
`define PSCC_A_ROLE 32'h60000034
`define PSCC_A_SLOTVER 32'h60000038
`define PSCC_A_SRCSEL 32'h60000058
`define PSCC_A_SEQSTOP 32'h6400007C
`define PSCC_A_STREL 32'h64000074
`define PSCC_IRQ_N 9
`define PSCC_IRQ_MASK_RST 9'h000
`define PSCC_ROLE_RST 1'h0
`define PSCC_SRCSEL_RST 1'h0
`define PSCC_IRQ_PSTOP_BIT 10
`define PSCC_IRQ_AQERR_BIT 11
`define PSCC_IRQ_VEC_LSB 12
`define PSCC_DLY_W 29
`define PSCC_DLY_LO_W 16
`define PSCC_DLY_HI_W 13
`define PSCC_DLY_STEP_PS 12500
`define PSCC_CLK_PERIOD_PS 25000
`define PSCC_DLY_STEPS_PER_CYC (`PSCC_CLK_PERIOD_PS / `PSCC_DLY_STEP_PS)
`define PSCC_BUS_LAT 1
`endif

// file: verilog/pscc_pkg.sv
// Types shared by the pulse sequencer channel control block.
// Assumes the constants header is compiled alongside.
package pscc_pkg;
  typedef enum logic {PSCC_IDLE, PSCC_RUN} pscc_seq_e;
  // Processor side access, one cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } pscc_bus_s;
  // Sequencer events, one cycle pulses
  typedef struct packed {
    logic [8:0] src;
    logic prog_stop;
    logic aq_stop_err;
    logic [3:0] vec;
    logic vec_load;
  } pscc_evt_s;
endpackage : pscc_pkg

// file: verilog/pscc_irq.sv
// Interrupt mask and sticky pending bits of one sequencer channel.
// Assumes event pulses and bus strobes synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_regs.svh"
module pscc_irq import pscc_pkg::*; #(
  parameter int N = `PSCC_IRQ_N
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic seq_clr,
  input wire pscc_evt_s evt,
  input wire logic mask_wr,
  input wire logic pend_wr,
  input wire logic [15:0] wdata,
  output logic [N-1:0] mask,
  output logic [15:0] pend_word,
  output logic irq_out
);
  logic [N-1:0] pend;
  logic pstop;
  logic aqerr;
  logic [3:0] vec;

  if (N != 9) begin : g_chk
    $error("pscc_irq serves exactly nine sources");
  end

  // Mask, cleared by reset and sequencer reset
  always_ff @(posedge core_clk) begin
    if (srst || seq_clr) begin
      mask <= `PSCC_IRQ_MASK_RST; // RL12
    end else if (mask_wr) begin
      mask <= wdata[N-1:0]; // RL12
    end
  end

  // Sticky bits: a new event wins over a write-one clear in the same cycle
  for (genvar i = 0; i < N; i++) begin : g_pend
    always_ff @(posedge core_clk) begin
      if (srst || seq_clr) begin
        pend[i] <= 1'b0;
      end else if (evt.src[i]) begin
        pend[i] <= 1'b1; // RL13
      end else if (pend_wr && wdata[i]) begin
        pend[i] <= 1'b0; // RL15
      end
    end
  end

  // Status bits 10 and 11 follow the same write-one clear; the vector changes only on a load or a reset
  always_ff @(posedge core_clk) begin
    if (srst || seq_clr) begin
      pstop <= 1'b0;
      aqerr <= 1'b0;
      vec <= 4'h0;
    end else begin
      if (evt.prog_stop) begin
        pstop <= 1'b1; // RL16
      end else if (pend_wr && wdata[`PSCC_IRQ_PSTOP_BIT]) begin
        pstop <= 1'b0;
      end
      if (evt.aq_stop_err) begin
        aqerr <= 1'b1; // RL16
      end else if (pend_wr && wdata[`PSCC_IRQ_AQERR_BIT]) begin
        aqerr <= 1'b0;
      end
      if (evt.vec_load) begin
        vec <= evt.vec; // RL17
      end
    end
  end

  assign pend_word = {vec, aqerr, pstop, 1'b0, pend}; // RL16 RL17
  assign irq_out = |(pend & mask); // RL14

  a_irq_follows: assert property (@(posedge core_clk) disable iff (srst) // RL14
    (mask_wr && |(wdata[N-1:0] & pend) && !seq_clr) |=> irq_out)
    else $error("unmasked pending source left irq low");
  a_evt_sets: assert property (@(posedge core_clk) disable iff (srst) // RL15
    (evt.src[0] && !seq_clr) |=> pend[0]) else $error("event lost against clear");
  a_w1c_clears: assert property (@(posedge core_clk) disable iff (srst) // RL15
    (pend_wr && wdata[1] && !evt.src[1]) |=> !pend[1]) else $error("write one did not clear");
endmodule : pscc_irq
`default_nettype wire

// file: verilog/pscc_delay.sv
// 29-bit start delay counter loaded through two 16-bit locations.
// Assumes one cycle strobes on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_regs.svh"
module pscc_delay #(
  parameter int W = `PSCC_DLY_W,
  parameter int STEPS = `PSCC_DLY_STEPS_PER_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic lo_wr,
  input wire logic hi_wr,
  input wire logic [15:0] wdata,
  input wire logic go,
  input wire logic abort,
  output logic [15:0] lo_value,
  output logic busy,
  output logic done
);
  logic [W-1:0] load;
  logic [W-1:0] cnt;

  if (W != `PSCC_DLY_LO_W + `PSCC_DLY_HI_W || STEPS < 1) begin : g_chk
    $error("pscc_delay width or step rate not supported");
  end

  // Load value: low word then upper 13 bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load <= '0;
    end else begin
      if (lo_wr) begin
        load[`PSCC_DLY_LO_W-1:0] <= wdata; // RL5
      end
      if (hi_wr) begin
        load[W-1:`PSCC_DLY_LO_W] <= wdata[`PSCC_DLY_HI_W-1:0]; // RL5
      end
    end
  end
  assign lo_value = load[`PSCC_DLY_LO_W-1:0]; // RL6

  // Each clock is two 12.5 ns steps, so the count drops by STEPS per cycle
  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (go) begin
      cnt <= load; // RL4
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && cnt > W'(STEPS)) begin
      cnt <= cnt - W'(STEPS); // RL4
      done <= 1'b0;
    end else begin
      busy <= 1'b0;
      done <= busy;
      cnt <= '0;
    end
  end

  a_done_once: assert property (@(posedge core_clk) disable iff (srst) // RL4
    done |=> !done) else $error("delay done longer than one cycle");
  a_zero_delay: assert property (@(posedge core_clk) disable iff (srst) // RL4
    (go && load == '0 && !abort) |=> busy ##1 done) else $error("zero delay not two cycles");
endmodule : pscc_delay
`default_nettype wire

// file: verilog/pscc_ctrl.sv
// Control and status register bank of one pulse sequencer channel.
// Assumes the processor memory port is synchronous to core_clk with one
// cycle read and write strobes; sequencer events arrive as pulses.
//
// Overview of operation
// RL1 - Status bit 2 reads 1 while the channel waits after a wait instruction.
// RL2 - Bit 1 low means master suspended; channel halts, sets suspend, raises irq four.
// RL3 - Status bit 0 is this channel's own suspend status.
// RL4 - A 29-bit counter sets the start delay in 12.5 ns steps.
// RL5 - Software loads low 16 bits and high 13 bits through two locations.
// RL6 - Low delay register reads back its stored value; high register is write-only.
// RL7 - Any write to local start moves IDLE to RUN, following the global start.
// RL8 - Reset or error interrupt forces IDLE and clears a pending acquisition start.
// RL9 - Sequencer reset write forces IDLE, clears duration and control and status.
// RL10 - Sequencer reset leaves the global acquisition start untouched.
// RL11 - Stop write, start-release write or reset also drop RUN to IDLE.
// RL12 - Nine-bit interrupt mask, one enables a source, resets to zero.
// RL13 - Sources 0 to 8 are program, stop, instruction, config, suspend, word, empty, if/else, nesting.
// RL14 - Pending bits read active high; masked sources drive irq line four.
// RL15 - Writing one clears a pending bit, writing zero leaves it.
// RL16 - Bit 9 unused, bit 10 programmed stop, bit 11 acquisition stop error.
// RL17 - Bits 15 to 12 hold a programmable vector, bit 12 least significant.
// RL18 - Configuration bits 15 to 13 give the board function code.
// RL19 - Three-bit channel number counts down; 111 is channel one.
// RL20 - Frequency and gradient channels report the attached output device in bits 1 to 0.
// RL21 - Timing channels report the fitted pulse adapter in bits 1 to 0.
// RL22 - Slot register holds slot address, board revision and subrevision.
// RL23 - Role bit selects frequency controller at 0 and gradient controller at 1.
// RL24 - Role bit survives a sequencer reset; only power-up clears it.
// RL25 - Source bit routes FIFO at 0, bypass registers at 1; resets to 0.
// RL26 - Status bit 3 mirrors the master's if/else decision.
// RL27 - With source bit 1 the bypass registers drive the serial output.
// RL28 - Strobe addresses act on the access and ignore written data.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_regs.svh"
module pscc_ctrl import pscc_pkg::*; #(
  parameter int OUT_W = 49,
  parameter int DUR_W = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire pscc_bus_s bus,
  output logic [15:0] rdata,
  output logic ready,
  input wire pscc_evt_s evt,
  input wire logic global_acquisition_start,
  input wire logic wait_state,
  input wire logic suspend_window_n,
  input wire logic at_suspend_instr,
  input wire logic resume,
  input wire logic if_else_sel,
  input wire logic [11:0] status_upper,
  input wire logic [15:0] channel_config_in,
  input wire logic [15:0] slot_version_in,
  input wire logic [OUT_W-1:0] fifo_word,
  input wire logic [OUT_W-1:0] bypass_word,
  output logic [OUT_W-1:0] realtime_pulse_output,
  output pscc_seq_e seq_state,
  output logic acq_start_pending,
  output logic delay_busy,
  output logic channel_go,
  output logic own_suspend,
  output logic role_gradient,
  output logic bypass_sel,
  output logic [DUR_W-1:0] run_duration,
  output logic processor_irq_line_four
);
  logic wr_lo;
  logic wr_hi;
  logic wr_lstart;
  logic wr_seqrst;
  logic wr_mask;
  logic wr_pend;
  logic wr_role;
  logic wr_src;
  logic wr_stop;
  logic wr_strel;
  logic err_evt;
  logic dly_done;
  logic [15:0] dly_lo;
  logic [8:0] irq_mask;
  logic [15:0] irq_pend;
  logic [15:0] status_word;
  logic [15:0] next_rdata;
  pscc_evt_s evt_all;
  logic irq_raw;

  if (OUT_W < 1 || DUR_W < 1) begin : g_chk
    $error("pscc_ctrl widths must be positive");
  end

  // Address match for a write strobe; only the access counts, not data
  function automatic logic hit_wr(input pscc_bus_s b, input logic [31:0] a);
    hit_wr = b.wr && (b.addr == a);
  endfunction : hit_wr

  // Write decode
  // Status is read-only and has no write decode
  assign wr_lo = hit_wr(bus, `PSCC_A_DLY_LO);
  assign wr_hi = hit_wr(bus, `PSCC_A_DLY_HI);
  assign wr_lstart = hit_wr(bus, `PSCC_A_LSTART); // RL28
  assign wr_seqrst = hit_wr(bus, `PSCC_A_SEQRST); // RL28
  assign wr_mask = hit_wr(bus, `PSCC_A_IRQ_MASK);
  assign wr_pend = hit_wr(bus, `PSCC_A_IRQ_PEND);
  assign wr_role = hit_wr(bus, `PSCC_A_ROLE);
  assign wr_src = hit_wr(bus, `PSCC_A_SRCSEL);
  assign wr_stop = hit_wr(bus, `PSCC_A_SEQSTOP);
  assign wr_strel = hit_wr(bus, `PSCC_A_STREL);

  // Error class sources: illegal instruction, configuration, word, nesting
  // Stop, suspend and empty FIFO are not errors
  assign err_evt = evt_all.src[2] | evt_all.src[3] | evt_all.src[5] | evt_all.src[8];

  // Suspend events from this channel join the external set as source 4
  always_comb begin
    evt_all = evt;
    evt_all.src[4] = evt.src[4] | (at_suspend_instr & ~suspend_window_n); // RL2
  end

  // RUN and IDLE of the sequencer part
  // Reset and errors win over any strobe
  always_ff @(posedge core_clk) begin
    if (srst || err_evt) begin
      seq_state <= PSCC_IDLE; // RL8
    end else if (wr_seqrst || wr_stop || wr_strel) begin
      seq_state <= PSCC_IDLE; // RL9 RL11
    end else if (wr_lstart) begin
      seq_state <= PSCC_RUN; // RL7
    end
  end

  // Pending acquisition start; the sequencer reset strobe is left out on
  // purpose so a start already seen on the shared bus is not lost
  always_ff @(posedge core_clk) begin
    if (srst || err_evt || wr_stop || wr_strel) begin
      acq_start_pending <= 1'b0; // RL8
    end else if (seq_state == PSCC_RUN && global_acquisition_start) begin
      acq_start_pending <= 1'b1; // RL7 RL10
    end else if (dly_done) begin
      acq_start_pending <= 1'b0;
    end
  end

  // Channel go pulse once the start delay has run out
  // A stop before the count ends suppresses it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      channel_go <= 1'b0;
    end else begin
      channel_go <= dly_done && seq_state == PSCC_RUN && acq_start_pending;
    end
  end

  // Operating duration, cleared by reset and sequencer reset
  // Wraps at full scale, no saturation
  always_ff @(posedge core_clk) begin
    if (srst || wr_seqrst) begin
      run_duration <= '0; // RL9
    end else if (seq_state == PSCC_RUN && acq_start_pending) begin
      run_duration <= run_duration + DUR_W'(1);
    end
  end

  // Own suspend: set on a suspend instruction while the master suspends
  // A set beats a resume in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst || wr_seqrst) begin
      own_suspend <= 1'b0;
    end else if (at_suspend_instr && !suspend_window_n) begin
      own_suspend <= 1'b1; // RL2 RL3
    end else if (resume) begin
      own_suspend <= 1'b0; // RL3
    end
  end

  // Role survives sequencer reset; only srst or a role write with bit 0 low returns it to frequency mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      role_gradient <= `PSCC_ROLE_RST; // RL24
    end else if (wr_role) begin
      role_gradient <= bus.wdata[0]; // RL23
    end
  end

  // Output source select
  // Bypass words come from another block
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bypass_sel <= `PSCC_SRCSEL_RST; // RL25
    end else if (wr_src) begin
      bypass_sel <= bus.wdata[0]; // RL25
    end
  end

  // Registered output word so the pins never see a decode glitch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      realtime_pulse_output <= '0;
    end else begin
      realtime_pulse_output <= bypass_sel ? bypass_word : fifo_word; // RL27
    end
  end

  // Status word; upper bits come from the sequencer and FIFO
  // Bit 1 is low while the master suspends
  assign status_word = {status_upper, if_else_sel, wait_state, suspend_window_n,
                        own_suspend}; // RL1 RL2 RL3 RL26

  // Read mux; write-only and unmapped locations read zero
  // Decoded in the strobe cycle only
  always_comb begin
    next_rdata = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `PSCC_A_STATUS: next_rdata = status_word;
        `PSCC_A_DLY_LO: next_rdata = dly_lo; // RL6
        `PSCC_A_IRQ_PEND: next_rdata = irq_pend; // RL14
        `PSCC_A_CHCFG: next_rdata = channel_config_in; // RL18 RL19 RL20 RL21
        `PSCC_A_SLOTVER: next_rdata = slot_version_in; // RL22
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Read data and ready one cycle after the strobe
  // Writes are answered too, so none stalls
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata <= 16'h0000;
      ready <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ready <= bus.rd | bus.wr;
    end
  end

  // Start delay; any drop to IDLE aborts it
  pscc_delay u_delay (
    .core_clk(core_clk),
    .srst(srst),
    .lo_wr(wr_lo),
    .hi_wr(wr_hi),
    .wdata(bus.wdata),
    .go(seq_state == PSCC_RUN && global_acquisition_start && !acq_start_pending),
    .abort(err_evt || wr_seqrst || wr_stop || wr_strel),
    .lo_value(dly_lo),
    .busy(delay_busy),
    .done(dly_done)
  );

  // Interrupt bank; sequencer reset clears it
  pscc_irq u_irq (
    .core_clk(core_clk),
    .srst(srst),
    .seq_clr(wr_seqrst),
    .evt(evt_all),
    .mask_wr(wr_mask),
    .pend_wr(wr_pend),
    .wdata(bus.wdata),
    .mask(irq_mask),
    .pend_word(irq_pend),
    .irq_out(irq_raw)
  );

  // Interrupt line is a flop so the processor never sees decode hazards
  // This costs one cycle of latency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      processor_irq_line_four <= 1'b0;
    end else begin
      processor_irq_line_four <= irq_raw; // RL14
    end
  end

  // Steps of a local start followed by the RUN state
  sequence s_local_start;
    wr_lstart && !wr_seqrst && !wr_stop && !wr_strel && !err_evt;
  endsequence
  sequence s_now_run;
    seq_state == PSCC_RUN;
  endsequence

  a_lstart_run: assert property (@(posedge core_clk) disable iff (srst) // RL7
    s_local_start |=> s_now_run) else $error("local start did not enter run");
  a_err_idle: assert property (@(posedge core_clk) disable iff (srst) // RL8
    err_evt |=> seq_state == PSCC_IDLE && !acq_start_pending)
    else $error("error did not force idle");
  a_seqrst_idle: assert property (@(posedge core_clk) disable iff (srst) // RL9
    wr_seqrst |=> seq_state == PSCC_IDLE && run_duration == '0)
    else $error("sequencer reset left run state or duration");
  a_seqrst_keep: assert property (@(posedge core_clk) disable iff (srst) // RL10
    (wr_seqrst && acq_start_pending && !err_evt && !wr_stop && !wr_strel && !dly_done)
    |=> acq_start_pending) else $error("sequencer reset dropped start");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (srst) // RL11
    (wr_stop || wr_strel) |=> seq_state == PSCC_IDLE) else $error("stop left run");
  a_role_keep: assert property (@(posedge core_clk) disable iff (srst) // RL24
    (wr_seqrst && !wr_role) |=> $stable(role_gradient)) else $error("role lost");
  a_src_route: assert property (@(posedge core_clk) disable iff (srst) // RL27
    bypass_sel |=> realtime_pulse_output == $past(bypass_word))
    else $error("bypass word not routed");
  a_susp_set: assert property (@(posedge core_clk) disable iff (srst) // RL2
    (at_suspend_instr && !suspend_window_n && !wr_seqrst) |=> own_suspend
    ##1 irq_pend[4]) else $error("suspend not recorded");
  a_irq_line: assert property (@(posedge core_clk) disable iff (srst) // RL14
    (evt_all.src[4] && irq_mask[4] && !wr_seqrst) |=> ##1 processor_irq_line_four)
    else $error("masked source did not raise irq");
  a_read_lo: assert property (@(posedge core_clk) disable iff (srst) // RL6
    (bus.rd && bus.addr == `PSCC_A_DLY_LO) |=> ready && rdata == $past(dly_lo))
    else $error("delay low read back wrong");

  // Reads return what stood in the strobe cycle
  sequence s_status_read;
    bus.rd && bus.addr == `PSCC_A_STATUS;
  endsequence

  sequence s_pend_read;
    bus.rd && bus.addr == `PSCC_A_IRQ_PEND;
  endsequence

  a_status_bits: assert property (@(posedge core_clk) disable iff (srst) // RL1 RL3 RL26
    s_status_read |=> rdata[3:0] ==
      $past({if_else_sel, wait_state, suspend_window_n, own_suspend}))
    else $error("status bits wrong");

  // Bit 9 has no source and reads zero
  a_pend_read: assert property (@(posedge core_clk) disable iff (srst) // RL14 RL16
    s_pend_read |=> rdata[9] == 1'b0 && rdata == $past(irq_pend))
    else $error("pending word read back wrong");

  // A go out of IDLE would fire an unarmed channel
  a_go_in_run: assert property (@(posedge core_clk) disable iff (srst) // RL8
    channel_go |-> $past(seq_state) == PSCC_RUN)
    else $error("go outside run");

  a_src_fifo: assert property (@(posedge core_clk) disable iff (srst) // RL25
    !bypass_sel |=> realtime_pulse_output == $past(fifo_word))
    else $error("fifo word not routed");

  a_role_write: assert property (@(posedge core_clk) disable iff (srst) // RL23
    wr_role |=> role_gradient == $past(bus.wdata[0]))
    else $error("role not written");
endmodule : pscc_ctrl
`default_nettype wire

// file: tb/pscc_proc_model.sv
// Processor model driving the channel block's register port.
// Assumes one-cycle strobes sampled on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_regs.svh"
module pscc_proc_model import pscc_pkg::*; (
  input wire logic core_clk,
  output var pscc_bus_s bus,
  input wire logic [15:0] rdata,
  input wire logic ready
);
  logic [15:0] last_rdata;
  logic last_ready;

  initial begin
    bus = '0;
  end

  // One access: strobe at a falling edge, answer taken while it stands
  task automatic access(input logic wr, input logic [31:0] addr, input logic [15:0] data);
    @(negedge core_clk);
    bus.wr = wr;
    bus.rd = ~wr;
    bus.addr = addr;
    bus.wdata = data;
    @(negedge core_clk);
    last_ready = ready;
    last_rdata = rdata;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    // Released lines carry junk so a stale address is never trusted
    bus.addr = ~addr;
    bus.wdata = ~data;
  endtask : access

  // Whole delay goes in as low half, then high half
  task automatic load_delay(input logic [28:0] value);
    access(1'b1, `PSCC_A_DLY_LO, value[15:0]);
    access(1'b1, `PSCC_A_DLY_HI, {3'h0, value[28:16]});
  endtask : load_delay
endmodule : pscc_proc_model
`default_nettype wire

// file: tb/test_pulse_sequencer_channel_ctrl.sv
// Self-checking bench of the channel control register bank.
// Assumes the package, constants header and processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pscc_regs.svh"
module test_pulse_sequencer_channel_ctrl import pscc_pkg::*;;
  logic core_clk, srst, ready, gstart, wait_st, win_n, at_sus, resume, ifel;
  logic pend, dbusy, go, own_sus, role, byp, irq;
  pscc_bus_s bus;
  pscc_evt_s evt, ev;
  pscc_seq_e state;
  logic [15:0] rdata, cfg_in, slot_in;
  logic [11:0] st_up;
  logic [48:0] fifo_w, byp_w, rt_out;
  logic [31:0] dur;
  logic [2:0] fn [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  pscc_ctrl i_dut (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .ready(ready), .evt(evt), .global_acquisition_start(gstart), .wait_state(wait_st),
    .suspend_window_n(win_n), .at_suspend_instr(at_sus), .resume(resume),
    .if_else_sel(ifel), .status_upper(st_up), .channel_config_in(cfg_in),
    .slot_version_in(slot_in), .fifo_word(fifo_w), .bypass_word(byp_w),
    .realtime_pulse_output(rt_out), .seq_state(state), .acq_start_pending(pend),
    .delay_busy(dbusy), .channel_go(go), .own_suspend(own_sus), .role_gradient(role),
    .bypass_sel(byp), .run_duration(dur), .processor_irq_line_four(irq));

  pscc_proc_model i_proc (.core_clk(core_clk), .bus(bus), .rdata(rdata), .ready(ready));

  // 25 ns clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Hang guard: the long delay run alone needs about 33k cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      conclude();
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    i_proc.access(1'b1, a, d);
  endtask : wr

  // Read with ready and data both compared
  task automatic rdchk(input string name, input logic [31:0] a, input logic [15:0] exp);
    i_proc.access(1'b0, a, 16'h0000);
    check("ready", 64'(i_proc.last_ready), 64'h1);
    check(name, 64'(i_proc.last_rdata), 64'(exp));
  endtask : rdchk

  task automatic fire(input pscc_evt_s e);
    @(negedge core_clk);
    evt = e;
    @(negedge core_clk);
    evt = '0;
  endtask : fire

  task automatic idle(input int k);
    repeat (k) @(negedge core_clk);
  endtask : idle

  task automatic conclude();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    srst = 1'b1;
    evt = '0;
    {gstart, wait_st, at_sus, resume, ifel} = 5'h00;
    win_n = 1'b1;
    st_up = 12'hA5C;
    cfg_in = 16'h0000;
    slot_in = 16'h9A3C; // Arbitrary slot and version word
    fifo_w = 49'h1_2345_6789_ABCD;
    byp_w = 49'h0_FEDC_BA98_7654;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    check("state", 64'(state), 64'(PSCC_IDLE));
    check("pending start", 64'(pend), 64'h0);
    check("role", 64'(role), 64'h0);
    check("source", 64'(byp), 64'h0);
    check("irq four", 64'(irq), 64'h0);
    // Delay low half reads back, high half and mask do not
    wr(`PSCC_A_DLY_LO, 16'hA5C3);
    rdchk("delay low", `PSCC_A_DLY_LO, 16'hA5C3);
    rdchk("delay high", `PSCC_A_DLY_HI, 16'h0000);
    rdchk("mask", `PSCC_A_IRQ_MASK, 16'h0000);
    rdchk("unmapped", 32'h600000F0, 16'h0000);
    // Status bits, then a suspend under a low suspend window
    wait_st = 1'b1;
    win_n = 1'b0;
    ifel = 1'b1;
    wr(`PSCC_A_IRQ_MASK, 16'h0010);
    rdchk("status", `PSCC_A_STATUS, 16'hA5CC);
    at_sus = 1'b1;
    idle(1);
    at_sus = 1'b0;
    idle(2);
    check("suspend", 64'(own_sus), 64'h1);
    check("suspend irq", 64'(irq), 64'h1);
    rdchk("status", `PSCC_A_STATUS, 16'hA5CD);
    rdchk("pending", `PSCC_A_IRQ_PEND, 16'h0010);
    resume = 1'b1;
    idle(1);
    resume = 1'b0;
    {wait_st, win_n, ifel} = 3'b010;
    wr(`PSCC_A_IRQ_PEND, 16'h0010);
    rdchk("status", `PSCC_A_STATUS, 16'hA5C2);
    // Every source: pending, masked, unmasked, write-zero, write-one
    wr(`PSCC_A_IRQ_MASK, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      ev = '0;
      ev.src[i] = 1'b1;
      fire(ev);
      idle(1);
      check("masked irq", 64'(irq), 64'h0);
      rdchk("pending", `PSCC_A_IRQ_PEND, 16'(1 << i));
      wr(`PSCC_A_IRQ_PEND, 16'h0000);
      rdchk("pending kept", `PSCC_A_IRQ_PEND, 16'(1 << i));
      wr(`PSCC_A_IRQ_MASK, 16'(1 << i));
      idle(1);
      check("unmasked irq", 64'(irq), 64'h1);
      wr(`PSCC_A_IRQ_PEND, 16'(1 << i));
      rdchk("pending cleared", `PSCC_A_IRQ_PEND, 16'h0000);
      check("irq off", 64'(irq), 64'h0);
      wr(`PSCC_A_IRQ_MASK, 16'h0000);
    end
    ev = '0;
    ev.prog_stop = 1'b1;
    ev.aq_stop_err = 1'b1;
    ev.vec = 4'h9;
    ev.vec_load = 1'b1;
    fire(ev);
    rdchk("pending upper", `PSCC_A_IRQ_PEND, 16'h9C00);
    // Role and output source
    wr(`PSCC_A_ROLE, 16'h0001);
    wr(`PSCC_A_SRCSEL, 16'h0001);
    idle(1);
    check("role", 64'(role), 64'h1);
    check("bypass out", 64'(rt_out), 64'(byp_w));
    // Identity words, one per board function
    foreach (fn[k]) begin
      cfg_in = {fn[k], 6'h2A, 3'(7 - k), 2'b00, 2'(k)};
      rdchk("config", `PSCC_A_CHCFG, {fn[k], 6'h2A, 3'(7 - k), 2'b00, 2'(k)});
    end
    rdchk("slot", `PSCC_A_SLOTVER, 16'h9A3C);
    // Start delay of 0x10010 steps, two steps per clock
    i_proc.load_delay(29'h0001_0010);
    wr(`PSCC_A_LSTART, 16'h0000);
    check("run", 64'(state), 64'(PSCC_RUN));
    gstart = 1'b1;
    n = 0;
    while (go !== 1'b1 && n < 40000) begin
      idle(1);
      n++;
    end
    check("go delay", 64'(n >= 32776 && n <= 32782), 64'h1);
    wr(`PSCC_A_SEQSTOP, 16'h0000);
    check("stop state", 64'(state), 64'(PSCC_IDLE));
    check("stop pending", 64'(pend), 64'h0);
    wr(`PSCC_A_LSTART, 16'h1234);
    idle(1);
    check("pending", 64'(pend), 64'h1);
    wr(`PSCC_A_IRQ_MASK, 16'h01FF);
    wr(`PSCC_A_SEQRST, 16'hFFFF);
    check("reset state", 64'(state), 64'(PSCC_IDLE));
    check("reset pending", 64'(pend), 64'h1);
    check("duration", 64'(dur), 64'h0);
    check("role kept", 64'(role), 64'h1);
    rdchk("pending", `PSCC_A_IRQ_PEND, 16'h0000);
    ev = '0;
    ev.src[0] = 1'b1;
    fire(ev);
    idle(2);
    check("mask cleared", 64'(irq), 64'h0);
    wr(`PSCC_A_STREL, 16'h0000);
    check("release pending", 64'(pend), 64'h0);
    // Zero delay start, then an error source drops RUN and the pending start
    i_proc.load_delay(29'h0000000);
    wr(`PSCC_A_LSTART, 16'h0000);
    idle(1);
    check("delay busy", 64'(dbusy), 64'h1);
    ev = '0;
    ev.src[2] = 1'b1;
    fire(ev);
    check("zero delay go", 64'(go), 64'h1);
    idle(1);
    check("error state", 64'(state), 64'(PSCC_IDLE));
    check("error pending", 64'(pend), 64'h0);
    gstart = 1'b0;
    wr(`PSCC_A_SRCSEL, 16'h0000);
    idle(1);
    check("fifo out", 64'(rt_out), 64'(fifo_w));
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    check("role reset", 64'(role), 64'h0);
    conclude();
  end
endmodule : test_pulse_sequencer_channel_ctrl
`default_nettype wire
